// [src/fcs_host.v]
// Purpose: host sequencer issuing flash command sequences and polling status
// Assumes: device decodes the command codes; one operation at a time
// Notes: status is refreshed by a fresh output-enable low pulse per poll
// Functional notes
// - program is setup code then data write at the target address
// - read-array code returns the device to array read after operations
// - suspend code halts programming; bit 6 tells suspended or done; resume restarts
// - while suspended host may read array except the location being programmed
// - erase is setup then confirm back to back, both to the block
// - suspend halts an erase; bit 6 tells; resume continues it
// - lock set is setup then set-confirm to the block; bit 4 on failure
// - lock clear is setup then clear-confirm; bit 5 on failure
// - host clears status after any detected error before retrying; fcs_host only flags RSP_ERROR, clearing needs an FCS_OP_CLEAR request
`timescale 1ns/100ps
`default_nettype none
`include "fcs_consts.vh"
module fcs_host (
  // clock and reset
  input wire REF_CLK,
  input wire RST_N,
  // user command port
  input wire CMD_VALID,
  input wire [2:0] CMD_OP,
  input wire [`FCS_ADDR_W-1:0] CMD_ADDR,
  input wire [`FCS_DATA_W-1:0] CMD_DATA,
  input wire FLASH_ENABLE,
  output wire CMD_READY,
  output reg RSP_VALID,
  output reg [`FCS_DATA_W-1:0] RSP_DATA,
  output reg [7:0] RSP_STATUS,
  output reg RSP_ERROR,
  output reg RSP_SUSPENDED,
  // flash pins
  output wire [`FCS_ADDR_W-1:0] F_ADDR,
  output wire F_CE_N,
  output wire F_OE_N,
  output wire F_WE_N,
  output reg F_RESET_POWERDOWN_N,
  input wire [`FCS_DATA_W-1:0] F_DQ_IN,
  output wire [`FCS_DATA_W-1:0] F_DQ_OUT,
  output wire F_DQ_OE
);
  localparam S_IDLE = 6'b000001;
  localparam S_WR1 = 6'b000010;
  localparam S_WR2 = 6'b000100;
  localparam S_POLL = 6'b001000;
  localparam S_EXIT = 6'b010000;
  localparam S_READ = 6'b100000;

  reg [5:0] state;
  reg [2:0] op;
  reg [`FCS_ADDR_W-1:0] addr;
  reg [`FCS_DATA_W-1:0] data;
  reg issued;
  reg start;
  reg is_write;
  reg [`FCS_ADDR_W-1:0] cyc_addr;
  reg [`FCS_DATA_W-1:0] cyc_data;
  reg en_s1;
  reg en_s2;
  wire [8:0] second_word;
  wire cyc_done;
  wire [`FCS_DATA_W-1:0] cyc_rdata;

  // second write of each two-write operation; zero means single write
  function [8:0] second_code;
    input [2:0] o;
    input [`FCS_DATA_W-1:0] d;
    begin
      case (o)
        `FCS_OP_PROGRAM: second_code = {1'b1, d[7:0]};
        `FCS_OP_ERASE: second_code = {1'b1, `FCS_CMD_CONFIRM};
        `FCS_OP_LOCK_SET: second_code = {1'b1, `FCS_CMD_LOCK_SET};
        `FCS_OP_LOCK_CLR: second_code = {1'b1, `FCS_CMD_CONFIRM};
        default: second_code = 9'h000;
      endcase
    end
  endfunction

  function [7:0] first_code;
    input [2:0] o;
    begin
      case (o)
        `FCS_OP_PROGRAM: first_code = `FCS_CMD_PROG_SETUP;
        `FCS_OP_ERASE: first_code = `FCS_CMD_ERASE_SETUP;
        `FCS_OP_LOCK_SET: first_code = `FCS_CMD_LOCK_SETUP;
        `FCS_OP_LOCK_CLR: first_code = `FCS_CMD_LOCK_SETUP;
        `FCS_OP_SUSPEND: first_code = `FCS_CMD_SUSPEND;
        `FCS_OP_RESUME: first_code = `FCS_CMD_CONFIRM;
        `FCS_OP_CLEAR: first_code = `FCS_CMD_CLEAR_STATUS;
        default: first_code = `FCS_CMD_READ_ARRAY;
      endcase
    end
  endfunction

  assign second_word = second_code(op, data);

  // one request at a time: no erase queue in the device
  assign CMD_READY = (state == S_IDLE) & RST_N;

  always @(posedge REF_CLK) begin
    en_s1 <= FLASH_ENABLE;
    en_s2 <= en_s1;
  end

  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      F_RESET_POWERDOWN_N <= 1'b0;
    end else begin
      // holding power-down low wipes the device status
      F_RESET_POWERDOWN_N <= en_s2;
    end
  end

  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      state <= S_IDLE;
      op <= `FCS_OP_READ;
      addr <= {`FCS_ADDR_W{1'b0}};
      data <= {`FCS_DATA_W{1'b0}};
      issued <= 1'b0;
      start <= 1'b0;
      is_write <= 1'b0;
      cyc_addr <= {`FCS_ADDR_W{1'b0}};
      cyc_data <= {`FCS_DATA_W{1'b0}};
      RSP_VALID <= 1'b0;
      RSP_DATA <= {`FCS_DATA_W{1'b0}};
      RSP_STATUS <= 8'h00;
      RSP_ERROR <= 1'b0;
      RSP_SUSPENDED <= 1'b0;
    end else begin
      start <= 1'b0;
      RSP_VALID <= 1'b0;
      case (state)
        S_IDLE: begin
          issued <= 1'b0;
          if (CMD_VALID) begin
            op <= CMD_OP;
            addr <= CMD_ADDR;
            data <= CMD_DATA;
            state <= (CMD_OP == `FCS_OP_READ) ? S_EXIT : S_WR1;
          end
        end
        S_WR1: begin
          if (!issued) begin
            start <= 1'b1;
            is_write <= 1'b1;
            cyc_addr <= addr;
            cyc_data <= {8'h00, first_code(op)};
            issued <= 1'b1;
          end else if (cyc_done) begin
            issued <= 1'b0;
            // clear-status only touches sticky errors, no engine work
            if (op == `FCS_OP_CLEAR) begin
              state <= S_EXIT;
            end else if (second_code(op, data) != 9'h000) begin
              state <= S_WR2;
            end else begin
              state <= S_POLL;
            end
          end
        end
        S_WR2: begin
          if (!issued) begin
            // confirm follows setup with nothing between
            start <= 1'b1;
            is_write <= 1'b1;
            cyc_addr <= addr;
            cyc_data <= (op == `FCS_OP_PROGRAM) ? data : {8'h00, second_word[7:0]};
            issued <= 1'b1;
          end else if (cyc_done) begin
            issued <= 1'b0;
            state <= S_POLL;
          end
        end
        S_POLL: begin
          if (!issued) begin
            // device presents status after commands, each read re-strobes oe
            start <= 1'b1;
            is_write <= 1'b0;
            cyc_addr <= addr;
            issued <= 1'b1;
          end else if (cyc_done) begin
            issued <= 1'b0;
            if (cyc_rdata[`FCS_BIT_READY]) begin
              RSP_STATUS <= cyc_rdata[7:0];
              // errors stay sticky, so any of them marks the result
              RSP_ERROR <= cyc_rdata[`FCS_BIT_PROG_ERR] | cyc_rdata[`FCS_BIT_VOLT_ERR] |
                           cyc_rdata[`FCS_BIT_PROTECT] | cyc_rdata[`FCS_BIT_UNLOCK_ERR];
              // suspended versus already completed
              RSP_SUSPENDED <= cyc_rdata[`FCS_BIT_SUSP];
              state <= S_EXIT;
            end
          end
        end
        S_EXIT: begin
          if (!issued) begin
            // back to array read so suspended reads return array data
            start <= 1'b1;
            is_write <= 1'b1;
            cyc_addr <= addr;
            cyc_data <= {8'h00, `FCS_CMD_READ_ARRAY};
            issued <= 1'b1;
          end else if (cyc_done) begin
            issued <= 1'b0;
            if (op == `FCS_OP_READ) begin
              state <= S_READ;
            end else begin
              RSP_VALID <= 1'b1;
              state <= S_IDLE;
            end
          end
        end
        S_READ: begin
          if (!issued) begin
            start <= 1'b1;
            is_write <= 1'b0;
            cyc_addr <= addr;
            issued <= 1'b1;
          end else if (cyc_done) begin
            RSP_DATA <= cyc_rdata;
            RSP_VALID <= 1'b1;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  fcs_bus_cycle u_cycle (
    .REF_CLK(REF_CLK),
    .RST_N(RST_N),
    .start(start),
    .is_write(is_write),
    .addr(cyc_addr),
    .wdata(cyc_data),
    .busy(),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .pin_addr(F_ADDR),
    .pin_ce_n(F_CE_N),
    .pin_oe_n(F_OE_N),
    .pin_we_n(F_WE_N),
    .pin_dq_in(F_DQ_IN),
    .pin_dq_out(F_DQ_OUT),
    .pin_dq_oe(F_DQ_OE)
  );
endmodule // fcs_host
`default_nettype wire

// [src/fcs_consts.vh]
// Purpose: constants for the flash command/status host controller
// Assumes: 8-bit command codes on the low data lines
// Notes: timing counts are in REF_CLK cycles at 100 MHz
`ifndef FCS_CONSTS_VH
`define FCS_CONSTS_VH
`define FCS_CMD_PROG_SETUP 8'h40
`define FCS_CMD_READ_ARRAY 8'hff
`define FCS_CMD_READ_STATUS 8'h70
`define FCS_CMD_CLEAR_STATUS 8'h50
`define FCS_CMD_ERASE_SETUP 8'h20
`define FCS_CMD_CONFIRM 8'hd0
`define FCS_CMD_SUSPEND 8'hb0
`define FCS_CMD_LOCK_SETUP 8'h60
`define FCS_CMD_LOCK_SET 8'h01
`define FCS_BIT_READY 7
`define FCS_BIT_SUSP 6
`define FCS_BIT_UNLOCK_ERR 5
`define FCS_BIT_PROG_ERR 4
`define FCS_BIT_VOLT_ERR 3
`define FCS_BIT_PROTECT 1
`define FCS_OP_PROGRAM 3'h0
`define FCS_OP_ERASE 3'h1
`define FCS_OP_LOCK_SET 3'h2
`define FCS_OP_LOCK_CLR 3'h3
`define FCS_OP_SUSPEND 3'h4
`define FCS_OP_RESUME 3'h5
`define FCS_OP_READ 3'h6
`define FCS_OP_CLEAR 3'h7
`define FCS_STROBE_NS 60
`define FCS_STROBE_CYC 4'd6
`define FCS_ADDR_W 24
`define FCS_DATA_W 16
`endif

// [src/fcs_bus_cycle.v]
// Purpose: one asynchronous write or read cycle on the flash pins
// Assumes: strobe width FCS_STROBE_CYC plus one cycles (70 ns at 10 ns per cycle)
// Notes: data bus is three signals; the board resolves the wire
`timescale 1ns/100ps
`default_nettype none
`include "fcs_consts.vh"
module fcs_bus_cycle (
  // clock and reset
  input wire REF_CLK,
  input wire RST_N,
  // request
  input wire start,
  input wire is_write,
  input wire [`FCS_ADDR_W-1:0] addr,
  input wire [`FCS_DATA_W-1:0] wdata,
  output wire busy,
  output reg done,
  output reg [`FCS_DATA_W-1:0] rdata,
  // flash pins
  output reg [`FCS_ADDR_W-1:0] pin_addr,
  output reg pin_ce_n,
  output reg pin_oe_n,
  output reg pin_we_n,
  input wire [`FCS_DATA_W-1:0] pin_dq_in,
  output reg [`FCS_DATA_W-1:0] pin_dq_out,
  output reg pin_dq_oe
);
  localparam S_IDLE = 3'b001;
  localparam S_STROBE = 3'b010;
  localparam S_HOLD = 3'b100;
  reg [2:0] state;
  reg [3:0] cnt;
  reg [`FCS_DATA_W-1:0] dq_s1;
  reg [`FCS_DATA_W-1:0] dq_s2;
  assign busy = (state != S_IDLE) | start;
  always @(posedge REF_CLK) begin
    dq_s1 <= pin_dq_in;
    dq_s2 <= dq_s1;
  end
  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      state <= S_IDLE;
      cnt <= 4'h0;
      done <= 1'b0;
      rdata <= {`FCS_DATA_W{1'b0}};
      pin_addr <= {`FCS_ADDR_W{1'b0}};
      pin_ce_n <= 1'b1;
      pin_oe_n <= 1'b1;
      pin_we_n <= 1'b1;
      pin_dq_out <= {`FCS_DATA_W{1'b0}};
      pin_dq_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        S_IDLE: begin
          if (start) begin
            pin_addr <= addr;
            pin_dq_out <= wdata;
            pin_dq_oe <= is_write;
            pin_ce_n <= 1'b0;
            pin_we_n <= ~is_write;
            pin_oe_n <= is_write;
            cnt <= `FCS_STROBE_CYC;
            state <= S_STROBE;
          end
        end
        S_STROBE: begin
          // strobe plus two sync stages so sampled data is settled
          if (cnt == 4'h0) begin
            rdata <= dq_s2;
            pin_we_n <= 1'b1;
            pin_oe_n <= 1'b1;
            pin_ce_n <= 1'b1;
            state <= S_HOLD;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        S_HOLD: begin
          // one cycle with strobes high: each read is a fresh low edge of oe
          pin_dq_oe <= 1'b0;
          done <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // fcs_bus_cycle
`default_nettype wire

// [tb/fcs_host_properties.sv]
// Purpose: port-level checks on the flash host sequencer
// Assumes: strobes low active, status held between operations
// Notes: sees top ports only, attached by bind
`timescale 1ns/100ps
`default_nettype none
module fcs_host_properties (
  // clock and reset
  input wire REF_CLK,
  input wire RST_N,
  // user side
  input wire CMD_VALID,
  input wire CMD_READY,
  input wire FLASH_ENABLE,
  input wire RSP_VALID,
  input wire [7:0] RSP_STATUS,
  input wire RSP_ERROR,
  input wire RSP_SUSPENDED,
  // flash pins
  input wire F_CE_N,
  input wire F_OE_N,
  input wire F_WE_N,
  input wire F_DQ_OE,
  input wire F_RESET_POWERDOWN_N
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  chk_write_selects: assert property (!F_WE_N |-> !F_CE_N)
    else $error("write strobe without chip enable");
  chk_no_contention: assert property (!F_OE_N |-> !F_DQ_OE)
    else $error("host drives data while output enable low");
  chk_oe_gap: assert property ($rose(F_OE_N) |=> F_OE_N)
    else $error("output enable high gap too short");
  chk_oe_width: assert property ($fell(F_OE_N) |-> !F_OE_N [*6])
    else $error("output enable low pulse too short");
  chk_rsp_pulse: assert property (RSP_VALID |=> !RSP_VALID)
    else $error("response valid longer than one cycle");
  chk_error_or: assert property (RSP_VALID |-> RSP_ERROR == (|(RSP_STATUS & 8'h3a)))
    else $error("error flag disagrees with status");
  chk_susp_flag: assert property (RSP_VALID |-> RSP_SUSPENDED == RSP_STATUS[6])
    else $error("suspended flag disagrees with status");
  chk_status_ready: assert property ($changed(RSP_STATUS) |-> RSP_STATUS[7])
    else $error("status taken while engine busy");
  chk_powerdown_low: assert property (!FLASH_ENABLE [*4] |-> !F_RESET_POWERDOWN_N)
    else $error("powerdown pin not low while disabled");
  chk_take_busy: assert property (CMD_VALID && CMD_READY |=> !CMD_READY)
    else $error("second request accepted while busy");
  cover property (RSP_VALID && RSP_ERROR);
  cover property (RSP_VALID && !RSP_ERROR);
  cover property (!F_RESET_POWERDOWN_N);
endmodule // fcs_host_properties
bind fcs_host fcs_host_properties u_chk (.REF_CLK, .RST_N, .CMD_VALID, .CMD_READY,
  .FLASH_ENABLE, .RSP_VALID, .RSP_STATUS, .RSP_ERROR, .RSP_SUSPENDED, .F_CE_N,
  .F_OE_N, .F_WE_N, .F_DQ_OE, .F_RESET_POWERDOWN_N);
`default_nettype wire

// [tb/fcs_flash_model.sv]
// Purpose: behavioural flash device answering the host pins
// Assumes: commands latched on first rise of write strobe or chip enable; block is bits 23:16
// Notes: engine busy a fixed 300 ns; released bus shows inverted last value
`timescale 1ns/100ps
`default_nettype none
module fcs_flash_model (
  // flash pins
  input wire [23:0] F_ADDR,
  input wire F_CE_N,
  input wire F_OE_N,
  input wire F_WE_N,
  input wire F_RESET_POWERDOWN_N,
  input wire [15:0] F_DQ_OUT,
  output logic [15:0] F_DQ_IN,
  // fault injection
  input wire logic volt_bad
);
  logic [15:0] mem [int];
  bit lock [int];
  logic [7:0] sr = 8'h80;
  logic [7:0] prev = 8'h00;
  logic [7:0] d;
  logic show_sr = 1'b0;
  logic armed = 1'b0;
  logic [15:0] last = 16'h0000;
  int b;
  always @(negedge F_RESET_POWERDOWN_N) begin
    sr = 8'h80;
    show_sr = 1'b0;
    prev = 8'h00;
  end
  // chip enable and write strobe may rise in one step, so arm while both are low
  always @(F_CE_N or F_WE_N) if (!F_CE_N && !F_WE_N) armed = 1'b1;
  else if (armed) begin
    armed = 1'b0;
    if (F_RESET_POWERDOWN_N) begin
    d = F_DQ_OUT[7:0];
    b = F_ADDR[23:16];
    show_sr = (d != 8'hff) || (prev == 8'h40);
    if (prev == 8'h40) begin
      if (volt_bad) sr[3] = 1'b1;
      else if (lock.exists(b)) sr[1] = 1'b1;
      else if (!sr[3]) mem[F_ADDR] = F_DQ_OUT;
    end else if (prev == 8'h20 && d == 8'hd0) begin
      for (int k = b << 16; k < (b + 1) << 16; k++) mem.delete(k);
    end else if (prev == 8'h60 && d == 8'h01) lock[b] = 1'b1;
    else if (prev == 8'h60 && d == 8'hd0) lock.delete();
    else if (prev == 8'h60) sr[5:4] = 2'b11;
    else if (d == 8'h50) sr = {sr[7:6], 6'h00};
    else if (d == 8'hb0) sr[6] = 1'b0;
    if (prev inside {8'h40, 8'h20, 8'h60}) begin
      sr[7] = 1'b0;
      #300 sr[7] = 1'b1;
      prev = 8'h00;
    end else prev = d;
    end
  end
  // status path is live, so every output enable low shows fresh bits
  always @* begin
    if (!F_CE_N && !F_OE_N) F_DQ_IN = show_sr ? {8'h00, sr} :
      (mem.exists(F_ADDR) ? mem[F_ADDR] : 16'hffff);
    else F_DQ_IN = ~last;
  end
  always @(posedge F_OE_N) last = F_DQ_IN;
endmodule // fcs_flash_model
`default_nettype wire

// [tb/fcs_host_tb.sv]
// Purpose: self-checking bench for the flash host sequencer
// Assumes: inputs change on the falling clock edge
// Notes: expected array, locks and status kept in a bench model
`timescale 1ns/100ps
`default_nettype none
`include "fcs_consts.vh"
module fcs_host_tb;
  logic ref_clk, rst_n, cmd_valid, flash_enable, volt_bad, cmd_ready, rsp_valid;
  logic rsp_error, rsp_susp, ce_n, oe_n, we_n, pd_n, dq_oe;
  logic [2:0] cmd_op;
  logic [23:0] cmd_addr, f_addr, la;
  logic [15:0] cmd_data, rsp_data, dq_in, dq_out;
  logic [7:0] rsp_status, exp_sr;
  logic [15:0] exp_mem [int];
  bit exp_lock [int];
  logic [31:0] seed = 32'd75;
  int num_errors = 0;
  int n_compared = 0;
  fcs_host u_fcs_host (.REF_CLK(ref_clk), .RST_N(rst_n), .CMD_VALID(cmd_valid),
    .CMD_OP(cmd_op), .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data), .FLASH_ENABLE(flash_enable),
    .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
    .RSP_STATUS(rsp_status), .RSP_ERROR(rsp_error), .RSP_SUSPENDED(rsp_susp),
    .F_ADDR(f_addr), .F_CE_N(ce_n), .F_OE_N(oe_n), .F_WE_N(we_n),
    .F_RESET_POWERDOWN_N(pd_n), .F_DQ_IN(dq_in), .F_DQ_OUT(dq_out), .F_DQ_OE(dq_oe));
  fcs_flash_model u_fcs_flash_model (.F_ADDR(f_addr), .F_CE_N(ce_n), .F_OE_N(oe_n),
    .F_WE_N(we_n), .F_RESET_POWERDOWN_N(pd_n), .F_DQ_OUT(dq_out), .F_DQ_IN(dq_in),
    .volt_bad(volt_bad));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expv);
    n_compared++;
    if (seen !== expv) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, expv, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic op(input logic [2:0] o, input logic [23:0] a, input logic [15:0] d);
    int i;
    @(negedge ref_clk);
    for (i = 0; i < 50 && cmd_ready !== 1'b1; i++) @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_op = o;
    cmd_addr = a;
    cmd_data = d;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    for (i = 0; i < 4000 && rsp_valid !== 1'b1; i++) @(negedge ref_clk);
    if (i == 4000) num_errors++;
  endtask
  // program then read back; device side effects predicted after the program, before the checks
  task automatic prog(input logic [23:0] a, input logic [15:0] d);
    op(`FCS_OP_PROGRAM, a, d);
    la = a;
    if (volt_bad) exp_sr[3] = 1'b1;
    else if (exp_lock.exists(a[23:16])) exp_sr[1] = 1'b1;
    else if (!exp_sr[3]) exp_mem[a] = d;
    check("status", rsp_status, exp_sr);
    check("error", rsp_error, |(exp_sr & 8'h3a));
    op(`FCS_OP_READ, a, 16'h0000);
    check("data", rsp_data, exp_mem.exists(a) ? exp_mem[a] : 16'hffff);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #800000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    {rst_n, cmd_valid, volt_bad, cmd_op, cmd_addr, cmd_data} = '0;
    flash_enable = 1'b1;
    exp_sr = 8'h80;
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    for (int k = 0; k < 3; k++) prog({8'h01, 16'(xs())}, 16'(xs()));
    op(`FCS_OP_ERASE, 24'h010000, 16'h0000);
    exp_mem.delete();
    op(`FCS_OP_READ, la, 16'h0000);
    check("erased", rsp_data, 16'hffff);
    op(`FCS_OP_LOCK_SET, 24'h020000, 16'h0000);
    exp_lock[2] = 1'b1;
    check("lock", rsp_status, exp_sr);
    prog(24'h020010, 16'(xs()));
    prog(24'h030000, 16'(xs()));
    op(`FCS_OP_CLEAR, 24'h000000, 16'h0000);
    exp_sr = 8'h80;
    op(`FCS_OP_LOCK_CLR, 24'h000000, 16'h0000);
    exp_lock.delete();
    check("unlock", rsp_status, exp_sr);
    prog(24'h020010, 16'(xs()));
    volt_bad = 1'b1;
    prog(24'h040000, 16'(xs()));
    volt_bad = 1'b0;
    prog(24'h040002, 16'(xs()));
    op(`FCS_OP_SUSPEND, 24'h040002, 16'h0000);
    check("susp", rsp_susp, 16'h0000);
    op(`FCS_OP_READ, 24'h030000, 16'h0000);
    check("susp_read", rsp_data, exp_mem[24'h030000]);
    op(`FCS_OP_RESUME, 24'h040002, 16'h0000);
    check("resume", rsp_status, exp_sr);
    flash_enable = 1'b0;
    repeat (5) @(negedge ref_clk);
    check("powerdown", pd_n, 16'h0000);
    flash_enable = 1'b1;
    exp_sr = 8'h80;
    repeat (5) @(negedge ref_clk);
    prog(24'h040004, 16'(xs()));
    report_and_stop();
  end
endmodule // fcs_host_tb
`default_nettype wire
